// ===== logic/temp_sensor_pkg.sv
// Constants for the temperature sensor register pointer and register map
package temp_sensor_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam int CYCLES_PER_MS = CLK_HZ / 1000;

    // Register select codes
    localparam logic [1:0] SEL_TEMPERATURE = 2'h0;
    localparam logic [1:0] SEL_CONFIGURATION = 2'h1;
    localparam logic [1:0] SEL_LOW_THRESHOLD = 2'h2;
    localparam logic [1:0] SEL_HIGH_THRESHOLD = 2'h3;

    // Pointer layout
    localparam int POINTER_WIDTH = 8;
    localparam int SELECT_WIDTH = 2;
    localparam logic [7:0] POINTER_RESET = 8'h00;

    // Configuration layout and reset values
    localparam int RATE_LSB = 6;
    localparam logic [15:0] CONFIG_RESET = 16'h40A0;
    localparam logic [15:0] CONFIG_WRITE_MASK = 16'h9FC0;
    localparam logic [15:0] TEMPERATURE_RESET = 16'h0000;
    localparam logic [15:0] LOW_THRESHOLD_RESET = 16'h0000;
    localparam logic [15:0] HIGH_THRESHOLD_RESET = 16'h0000;

    // Conversion rate codes
    localparam logic [1:0] RATE_QUARTER = 2'h0;
    localparam logic [1:0] RATE_ONE = 2'h1;
    localparam logic [1:0] RATE_FOUR = 2'h2;
    localparam logic [1:0] RATE_EIGHT = 2'h3;

    // Times in ms and derived cycle counts
    localparam int CONV_TYP_MS = 36;
    localparam int CONV_MAX_MS = 51;
    localparam int PERIOD_QUARTER_MS = 4000;
    localparam int PERIOD_ONE_MS = 1000;
    localparam int PERIOD_FOUR_MS = 250;
    localparam int PERIOD_EIGHT_MS = 125;
    localparam int CONV_CYCLES = CONV_TYP_MS * CYCLES_PER_MS;
    localparam int PERIOD_QUARTER_CYCLES = PERIOD_QUARTER_MS * CYCLES_PER_MS;
    localparam int PERIOD_ONE_CYCLES = PERIOD_ONE_MS * CYCLES_PER_MS;
    localparam int PERIOD_FOUR_CYCLES = PERIOD_FOUR_MS * CYCLES_PER_MS;
    localparam int PERIOD_EIGHT_CYCLES = PERIOD_EIGHT_MS * CYCLES_PER_MS;

    // Byte phases of a write transfer
    localparam logic [1:0] PHASE_POINTER = 2'h0;
    localparam logic [1:0] PHASE_MSB = 2'h1;
    localparam logic [1:0] PHASE_LSB = 2'h2;

    typedef enum {CONV_IDLE, CONV_BUSY} conv_state_t;
endpackage

// ===== logic/temp_sensor_regs.sv
// Pointer, register map and conversion scheduler of the temperature sensor
`timescale 1ns/100ps

module temp_sensor_regs #(
    parameter int CONV_CYCLES = temp_sensor_pkg::CONV_CYCLES,
    parameter int PERIOD_QUARTER_CYCLES = temp_sensor_pkg::PERIOD_QUARTER_CYCLES,
    parameter int PERIOD_ONE_CYCLES = temp_sensor_pkg::PERIOD_ONE_CYCLES,
    parameter int PERIOD_FOUR_CYCLES = temp_sensor_pkg::PERIOD_FOUR_CYCLES,
    parameter int PERIOD_EIGHT_CYCLES = temp_sensor_pkg::PERIOD_EIGHT_CYCLES
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic xfer_start_in,
    input wire logic wr_valid_in,
    input wire logic [7:0] wr_data_in,
    input wire logic rd_req_in,
    input wire logic [15:0] sample_in,
    output logic [7:0] rd_data_out,
    output logic rd_valid_out,
    output logic [7:0] pointer_out,
    output logic [15:0] configuration_out,
    output logic [15:0] low_threshold_out,
    output logic [15:0] high_threshold_out,
    output logic [15:0] temperature_result_out,
    output logic converting_out,
    output logic result_load_out
);
    logic [1:0] select;
    logic [1:0] wr_phase;
    logic [7:0] msb_hold;
    logic rd_lsb;
    logic [15:0] configuration;
    logic [15:0] low_threshold;
    logic [15:0] high_threshold;
    logic [15:0] temperature_result;
    temp_sensor_pkg::conv_state_t conv_state;
    logic [31:0] period_cnt;
    logic [31:0] conv_cnt;
    logic [31:0] period_len;
    logic result_load;
    logic commit;
    logic [15:0] commit_word;
    logic [15:0] read_word;

    function automatic logic [15:0] reg_mux(input logic [1:0] sel, input logic [15:0] t,
                                            input logic [15:0] c, input logic [15:0] l,
                                            input logic [15:0] h);
        case (sel)
            temp_sensor_pkg::SEL_TEMPERATURE: reg_mux = t;
            temp_sensor_pkg::SEL_CONFIGURATION: reg_mux = c;
            temp_sensor_pkg::SEL_LOW_THRESHOLD: reg_mux = l;
            default: reg_mux = h;
        endcase
    endfunction

    function automatic logic [31:0] rate_period(input logic [1:0] rate);
        case (rate)
            temp_sensor_pkg::RATE_QUARTER: rate_period = 32'(PERIOD_QUARTER_CYCLES);
            temp_sensor_pkg::RATE_ONE: rate_period = 32'(PERIOD_ONE_CYCLES);
            temp_sensor_pkg::RATE_FOUR: rate_period = 32'(PERIOD_FOUR_CYCLES);
            default: rate_period = 32'(PERIOD_EIGHT_CYCLES);
        endcase
    endfunction

    assign commit = wr_valid_in && !xfer_start_in && (wr_phase == temp_sensor_pkg::PHASE_LSB);
    assign commit_word = {msb_hold, wr_data_in};
    assign read_word = reg_mux(select, temperature_result, configuration, low_threshold, high_threshold);
    assign period_len = rate_period(configuration[temp_sensor_pkg::RATE_LSB +: 2]);
    assign result_load = (conv_state == temp_sensor_pkg::CONV_BUSY) && (conv_cnt == 32'(CONV_CYCLES - 1));

    // Pointer select and write byte phase
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            select <= temp_sensor_pkg::POINTER_RESET[1:0];
            wr_phase <= temp_sensor_pkg::PHASE_POINTER;
            msb_hold <= 8'h00;
        end else if (xfer_start_in) begin
            wr_phase <= temp_sensor_pkg::PHASE_POINTER;
        end else if (wr_valid_in) begin
            case (wr_phase)
                temp_sensor_pkg::PHASE_POINTER: begin
                    select <= wr_data_in[1:0];
                    wr_phase <= temp_sensor_pkg::PHASE_MSB;
                end
                temp_sensor_pkg::PHASE_MSB: begin
                    msb_hold <= wr_data_in;
                    wr_phase <= temp_sensor_pkg::PHASE_LSB;
                end
                default: begin
                    wr_phase <= temp_sensor_pkg::PHASE_MSB;
                end
            endcase
        end
    end

    // Writable registers, committed on the LSB byte; configuration takes only its CONFIG_WRITE_MASK bits
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            configuration <= temp_sensor_pkg::CONFIG_RESET;
            low_threshold <= temp_sensor_pkg::LOW_THRESHOLD_RESET;
            high_threshold <= temp_sensor_pkg::HIGH_THRESHOLD_RESET;
        end else if (commit) begin
            case (select)
                temp_sensor_pkg::SEL_CONFIGURATION: begin
                    configuration <= (configuration & ~temp_sensor_pkg::CONFIG_WRITE_MASK)
                        | (commit_word & temp_sensor_pkg::CONFIG_WRITE_MASK);
                end
                temp_sensor_pkg::SEL_LOW_THRESHOLD: low_threshold <= commit_word;
                temp_sensor_pkg::SEL_HIGH_THRESHOLD: high_threshold <= commit_word;
                default: ;
            endcase
        end
    end

    // Read path, MSB byte first
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            rd_lsb <= 1'b0;
            rd_data_out <= 8'h00;
            rd_valid_out <= 1'b0;
        end else begin
            rd_valid_out <= rd_req_in && !xfer_start_in;
            if (xfer_start_in) begin
                rd_lsb <= 1'b0;
            end else if (rd_req_in) begin
                rd_lsb <= !rd_lsb;
                if (rd_lsb) begin
                    rd_data_out <= read_word[7:0];
                end else begin
                    rd_data_out <= read_word[15:8];
                end
            end
        end
    end

    // Conversion scheduler
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            conv_state <= temp_sensor_pkg::CONV_BUSY;
            conv_cnt <= 32'h0000_0000;
            period_cnt <= 32'h0000_0000;
        end else begin
            if (period_cnt >= period_len - 32'h0000_0001) begin
                period_cnt <= 32'h0000_0000;
            end else begin
                period_cnt <= period_cnt + 32'h0000_0001;
            end
            case (conv_state)
                temp_sensor_pkg::CONV_IDLE: begin
                    conv_cnt <= 32'h0000_0000;
                    if (period_cnt >= period_len - 32'h0000_0001) begin
                        conv_state <= temp_sensor_pkg::CONV_BUSY;
                    end
                end
                temp_sensor_pkg::CONV_BUSY: begin
                    if (result_load) begin
                        conv_state <= temp_sensor_pkg::CONV_IDLE;
                        conv_cnt <= 32'h0000_0000;
                    end else begin
                        conv_cnt <= conv_cnt + 32'h0000_0001;
                    end
                end
                default: conv_state <= temp_sensor_pkg::CONV_IDLE;
            endcase
        end
    end

    // Result register
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            temperature_result <= temp_sensor_pkg::TEMPERATURE_RESET;
        end else if (result_load) begin
            temperature_result <= sample_in;
        end
    end

    assign pointer_out = {6'h00, select};
    assign configuration_out = configuration;
    assign low_threshold_out = low_threshold;
    assign high_threshold_out = high_threshold;
    assign temperature_result_out = temperature_result;
    assign converting_out = (conv_state == temp_sensor_pkg::CONV_BUSY);
    assign result_load_out = result_load;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    property p_pointer_upper_zero;
        rd_valid_out |-> pointer_out[7:2] == 6'h00 && $past(pointer_out[7:2]) == 6'h00;
    endproperty
    a_pointer_upper_zero: assert property (p_pointer_upper_zero) else $error("Pointer upper bits not zero");

    property p_pointer_load;
        wr_valid_in && !xfer_start_in && wr_phase == temp_sensor_pkg::PHASE_POINTER
            |=> pointer_out == {6'h00, $past(wr_data_in[1:0])};
    endproperty
    a_pointer_load: assert property (p_pointer_load) else $error("Pointer select not loaded");

    property p_result_stable;
        !result_load |=> $stable(temperature_result_out);
    endproperty
    a_result_stable: assert property (p_result_stable) else $error("Result changed outside conversion end");

    property p_result_readonly;
        commit && select == temp_sensor_pkg::SEL_TEMPERATURE && !result_load |=> $stable(temperature_result_out);
    endproperty
    a_result_readonly: assert property (p_result_readonly) else $error("Write reached result register");

    property p_read_msb_first;
        rd_req_in && !xfer_start_in && !rd_lsb
            |=> rd_valid_out && rd_data_out == $past(read_word[15:8]);
    endproperty
    a_read_msb_first: assert property (p_read_msb_first) else $error("First read byte not MSB");

    property p_threshold_write;
        commit && select == temp_sensor_pkg::SEL_HIGH_THRESHOLD
            |=> high_threshold_out == {$past(msb_hold), $past(wr_data_in)};
    endproperty
    a_threshold_write: assert property (p_threshold_write) else $error("High threshold write lost");

    property p_rate_reset;
        $rose(resetn_in) |-> configuration[7:6] == temp_sensor_pkg::RATE_FOUR;
    endproperty
    a_rate_reset: assert property (@(posedge clk_in) p_rate_reset) else $error("Rate not four per second");

    property p_conv_bound;
        conv_state == temp_sensor_pkg::CONV_BUSY |-> conv_cnt < 32'(CONV_CYCLES);
    endproperty
    a_conv_bound: assert property (p_conv_bound) else $error("Conversion overran its time");

    property p_period_bound;
        period_cnt < period_len || $changed(configuration);
    endproperty
    a_period_bound: assert property (p_period_bound) else $error("Period counter beyond rate");
endmodule

// ===== sim/temp_host_model.sv
// Serial host stand-in that moves bytes to and from the register block
`timescale 1ns/100ps
module temp_host_model (
    input wire logic clk_in,
    input wire logic rd_valid_in,
    input wire logic [7:0] rd_data_in,
    output logic xfer_start_out,
    output logic wr_valid_out,
    output logic [7:0] wr_data_out,
    output logic rd_req_out
);
    int timeouts = 0;
    initial begin
        xfer_start_out = 1'b0;
        wr_valid_out = 1'b0;
        wr_data_out = 8'h5A;
        rd_req_out = 1'b0;
    end
    task automatic start_xfer();
        @(negedge clk_in);
        xfer_start_out = 1'b1;
        @(negedge clk_in);
        xfer_start_out = 1'b0;
    endtask
    // Pointer byte, then optional data, most significant byte first
    task automatic send(input logic [7:0] p, input logic [15:0] d, input bit with_data);
        start_xfer();
        wr_valid_out = 1'b1;
        wr_data_out = p;
        @(negedge clk_in);
        if (with_data) begin
            wr_data_out = d[15:8];
            @(negedge clk_in);
            wr_data_out = d[7:0];
            @(negedge clk_in);
        end
        wr_valid_out = 1'b0;
        wr_data_out = ~wr_data_out;
    endtask
    task automatic get_byte(output logic [7:0] b);
        int i;
        rd_req_out = 1'b1;
        @(negedge clk_in);
        rd_req_out = 1'b0;
        for (i = 0; i < 4 && rd_valid_in !== 1'b1; i++) begin
            @(negedge clk_in);
        end
        if (i == 4) begin
            timeouts++;
        end
        b = rd_data_in;
        @(negedge clk_in);
    endtask
    task automatic read_reg(input logic [1:0] sel, output logic [15:0] d);
        send({6'h00, sel}, 16'h0000, 1'b0);
        start_xfer();
        get_byte(d[15:8]);
        get_byte(d[7:0]);
    endtask
endmodule

// ===== sim/tb_temp_sensor_regs.sv
// Self-checking bench for the temperature sensor register block
`timescale 1ns/100ps
module tb_temp_sensor_regs;
    localparam int CONV = 20;
    localparam int PER [4] = '{400, 100, 50, 40};
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic [15:0] sample_in = 16'h1357;
    logic xfer_start, wr_valid, rd_req, rd_valid, result_load, converting;
    logic [7:0] wr_data, rd_data, pointer;
    logic [15:0] cfg, lo, hi, temp, rv;
    logic [15:0] wval [4] = '{16'hBEEF, 16'hFFFF, 16'h1234, 16'hABCD};
    logic [15:0] exp_v [4];
    int failures = 0;
    int compares = 0;
    int n;
    always #10 clk_in = ~clk_in;
    temp_sensor_regs #(.CONV_CYCLES(CONV), .PERIOD_QUARTER_CYCLES(PER[0]), .PERIOD_ONE_CYCLES(PER[1]),
        .PERIOD_FOUR_CYCLES(PER[2]), .PERIOD_EIGHT_CYCLES(PER[3])) temp_sensor_regs_i (
        .clk_in(clk_in), .resetn_in(resetn_in), .xfer_start_in(xfer_start), .wr_valid_in(wr_valid),
        .wr_data_in(wr_data), .rd_req_in(rd_req), .sample_in(sample_in), .rd_data_out(rd_data),
        .rd_valid_out(rd_valid), .pointer_out(pointer), .configuration_out(cfg), .low_threshold_out(lo),
        .high_threshold_out(hi), .temperature_result_out(temp), .converting_out(converting),
        .result_load_out(result_load));
    temp_host_model temp_host_model_i (.clk_in(clk_in), .rd_valid_in(rd_valid), .rd_data_in(rd_data),
        .xfer_start_out(xfer_start), .wr_valid_out(wr_valid), .wr_data_out(wr_data), .rd_req_out(rd_req));
    task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_count(input int got, input int exp);
        compares++;
        if (got != exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        failures += temp_host_model_i.timeouts;
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic wait_load(output int cnt);
        cnt = 0;
        do begin
            @(negedge clk_in);
            cnt++;
        end while (result_load !== 1'b1 && cnt < 1000);
        if (cnt >= 1000) begin
            failures++;
            complete_run();
        end
    endtask
    initial begin
        repeat (3) @(negedge clk_in);
        resetn_in = 1'b1;
        check_val({8'h00, pointer}, 16'h0000);
        check_val({15'h0000, converting}, 16'h0001);
        wait_load(n);
        check_count(n, CONV - 1);
        @(negedge clk_in);
        check_val(temp, 16'h1357);
        check_val({15'h0000, converting}, 16'h0000);
        sample_in = 16'h2468;
        repeat (5) @(negedge clk_in);
        check_val(temp, 16'h1357);
        sample_in = 16'h1357;
        exp_v = '{16'h1357, temp_sensor_pkg::CONFIG_RESET, 16'h0000, 16'h0000};
        for (int s = 0; s < 4; s++) begin
            temp_host_model_i.read_reg(s[1:0], rv);
            check_val(rv, exp_v[s]);
        end
        temp_host_model_i.send(8'hFF, 16'h0000, 1'b0);
        check_val({8'h00, pointer}, 16'h0003);
        for (int s = 0; s < 4; s++) begin
            temp_host_model_i.send(8'hFC | s[7:0], wval[s], 1'b1);
        end
        exp_v[1] = (16'hFFFF & temp_sensor_pkg::CONFIG_WRITE_MASK)
            | (temp_sensor_pkg::CONFIG_RESET & ~temp_sensor_pkg::CONFIG_WRITE_MASK);
        exp_v[2] = 16'h1234;
        exp_v[3] = 16'hABCD;
        check_val(hi, 16'hABCD);
        check_val(lo, 16'h1234);
        for (int s = 0; s < 4; s++) begin
            temp_host_model_i.read_reg(s[1:0], rv);
            check_val(rv, exp_v[s]);
        end
        for (int r = 0; r < 4; r++) begin
            rv = temp_sensor_pkg::CONFIG_RESET;
            rv[7:6] = r[1:0];
            temp_host_model_i.send(8'h01, rv, 1'b1);
            wait_load(n);
            wait_load(n);
            check_count(n, PER[r]);
        end
        complete_run();
    end
endmodule
